/* common/temp_monitor_consts.svh */
// offsets, field positions, reset values and timing counts of the temperature monitor core
`ifndef TEMP_MONITOR_CONSTS_SVH
`define TEMP_MONITOR_CONSTS_SVH

`define CLK_PERIOD_NS 100
`define CLK_HZ 10000000
`define NS_PER_MS 1000000
`define CONV_TIME_NS 31250000
`define CONV_CYC (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define SMB_TIMEOUT_MIN_MS 25
`define SMB_TIMEOUT_MAX_MS 35
`define SMB_TO_CYC (((`SMB_TIMEOUT_MIN_MS + `SMB_TIMEOUT_MAX_MS) / 2) * `NS_PER_MS / `CLK_PERIOD_NS)
`define TACH_CLK_HZ 90000
`define TACH_DIV (`CLK_HZ / `TACH_CLK_HZ)
// the pin filter already drops one-cycle spikes, so smart tach asks for a longer high
`define TACH_SMART_MIN 3
`define TACH_FULL 16'hffff

`define A_LOCAL_TEMP 8'h00
`define A_REMOTE_HI 8'h04
`define A_REMOTE_LO 8'h08
`define A_CONFIG 8'h0c
`define A_STATUS 8'h10
`define A_SP_BASE 8'h14
`define A_SP_END 8'h3c
`define A_TACH_COUNT 8'h3c
`define A_IRQ_STATUS 8'h40
`define A_IRQ_MASK 8'h44

`define SP_LOCAL_HIGH 0
`define SP_REMOTE_HIGH_HI 1
`define SP_REMOTE_HIGH_LO 2
`define SP_REMOTE_LOW_HI 3
`define SP_REMOTE_LOW_LO 4
`define SP_CRITICAL 5
`define SP_HYSTERESIS 6
`define SP_OFFSET_HI 7
`define SP_OFFSET_LO 8
`define SP_RATE 9
`define SP_COUNT 10

`define CFG_CMP_MODE 0
`define CFG_SMART_TACH 1
`define CFG_TACH_SEL 2
`define CFG_PWM_SB_DIS 5
`define CFG_STANDBY 6
`define CFG_ALERT_MASK 7

`define ST_LOCAL_HIGH 0
`define ST_REMOTE_HIGH 1
`define ST_REMOTE_LOW 2
`define ST_CRITICAL 3
`define ST_OPEN 4
`define ST_BUSY 7

`define IRQ_CONV 0
`define IRQ_LIMIT 1
`define IRQ_TACH 2
`define IRQ_SMB_TO 3

`define RST_LOCAL_HIGH 8'h46
`define RST_REMOTE_HIGH 8'h46
`define RST_CRITICAL 8'h55
`define RST_HYSTERESIS 8'h04
`define RST_CONFIG 8'h00

`endif

/* common/temp_monitor_pkg.sv */
// types shared by the temperature monitor core
package temp_monitor_pkg;
  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_CONV = 3'b010,
    CV_WAIT = 3'b100
  } conv_state_t;
  typedef logic signed [17:0] wide_temp_t;
endpackage : temp_monitor_pkg

/* design/pin_sync.sv */
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule : pin_sync

/* design/smbus_timeout.sv */
// bus-low watchdog that resets the serial interface and holds its drivers off
`timescale 1ns/10ps
module smbus_timeout #(
  parameter int unsigned TO_CYC = 300000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  output logic to_pulse,
  output logic hold
);
  logic [31:0] low_cnt_q;

  // either line low counts; the hold lasts until both lines are seen high again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= 32'h0;
      to_pulse <= 1'b0;
      hold <= 1'b0;
    end else begin
      to_pulse <= 1'b0;
      if (scl && sda) begin
        low_cnt_q <= 32'h0;
        hold <= 1'b0;
      end else if (low_cnt_q == TO_CYC - 1) begin
        low_cnt_q <= low_cnt_q + 32'h1;
        to_pulse <= 1'b1;
        hold <= 1'b1;
      end else if (low_cnt_q < TO_CYC) begin
        low_cnt_q <= low_cnt_q + 32'h1;
      end
    end
  end
endmodule : smbus_timeout

/* design/temp_monitor_limit_alert_core.sv */
// temperature monitor core: readings, offset, limit alerts, standby, tach, AHB-Lite registers
`timescale 1ns/10ps
`include "temp_monitor_consts.svh"

// Function
// - serial lines low past the timeout reset the interface and release both lines
// - each conversion compares local temperature against the local high limit
// - each conversion compares remote temperature against high, low and critical limits
// - alert when a reading is above high or critical, or below low
// - alert mask bit suppresses the alert output for every violation
// - hysteresis register widens the release point of each limit comparison
// - standby bit stops continuous conversions
// - a configuration bit chooses whether fan pwm runs during standby
// - local reading and every setpoint register are eight bits wide
// - remote reading is eleven bits left justified in a sixteen bit pair
// - signed remote offset pair is added to the remote reading
// - in tach mode the shared pin measures fan speed from tach pulses
// - smart tach mode ignores short pulses caused by switched fan power
// - in alert mode with alerts enabled a violation pulls the open-drain pin low
// - a conversion takes 31.25 ms; slower rates add idle time between them
// - each violation sets its status bit; any except busy or open drives alert
// - interrupt mode: status read clears bits and sets mask if any limit bit was set
module temp_monitor_limit_alert_core import temp_monitor_pkg::*; #(
  parameter int unsigned CONV_CYC = `CONV_CYC,
  parameter int unsigned SMB_TO_CYC = `SMB_TO_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] adc_local,
  input wire logic [10:0] adc_remote,
  input wire logic diode_open,
  input wire logic fan_pwm_req,
  output logic fan_pwm_o,
  output logic fan_pwm_oe,
  input wire logic smb_scl_i,
  input wire logic smb_scl_drive,
  output logic smb_scl_o,
  output logic smb_scl_oe,
  input wire logic smb_sda_i,
  input wire logic smb_sda_drive,
  output logic smb_sda_o,
  output logic smb_sda_oe,
  output logic smb_if_reset,
  input wire logic alert_tach_i,
  output logic alert_tach_o,
  output logic alert_tach_oe,
  output logic irq
);
  logic acc;
  logic ph_q;
  logic ack_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  logic [7:0] cfg_q;
  logic [7:0] sp_q [`SP_COUNT];
  logic sp_hit;
  logic [3:0] sp_idx;
  logic [7:0] local_temp_q;
  logic [15:0] remote_temp_q;
  logic [15:0] remote_sum;
  logic [4:0] status_q;
  logic [3:0] cond_q;
  logic [3:0] cond_d;
  logic status_clr;
  logic [3:0] irq_st_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_ev;
  logic [3:0] w1c;
  conv_state_t cv_q;
  logic [31:0] cv_cnt_q;
  logic [31:0] wait_len;
  logic conv_end;
  logic busy;
  logic standby;
  logic scl_f;
  logic sda_f;
  logic tach_f;
  logic to_pulse;
  logic to_hold;
  logic tach_prev_q;
  logic [6:0] div_q;
  logic [1:0] hi_run_q;
  logic tach_edge;
  logic [15:0] per_q;
  logic [15:0] tach_count_q;
  wide_temp_t t_loc;
  wide_temp_t t_rem;
  wide_temp_t hy;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  pin_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .clk(hclk), .rst_n(hresetn), .pin(smb_scl_i), .level(scl_f)
  );
  pin_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .clk(hclk), .rst_n(hresetn), .pin(smb_sda_i), .level(sda_f)
  );
  pin_sync #(.RST_VAL(1'b0)) u_sync_tach (
    .clk(hclk), .rst_n(hresetn), .pin(alert_tach_i), .level(tach_f)
  );
  smbus_timeout #(.TO_CYC(SMB_TO_CYC)) u_timeout (
    .clk(hclk), .rst_n(hresetn), .scl(scl_f), .sda(sda_f),
    .to_pulse(to_pulse), .hold(to_hold)
  );

  // bus slave: one wait state on every transfer so reads always see prior writes
  assign acc = hsel & htrans[1] & hready;
  assign hreadyout = ~(ph_q & ~ack_q);
  assign hresp = 1'b0;
  assign wr_en = ph_q & ~ack_q & wr_q;
  assign rd_en = ph_q & ~ack_q & ~wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      ack_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (acc) begin
      ph_q <= 1'b1;
      ack_q <= 1'b0;
      wr_q <= hwrite;
      addr_q <= haddr[7:0];
    end else if (ph_q & ack_q) begin
      ph_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (ph_q) begin
      ack_q <= 1'b1;
    end
  end

  assign sp_hit = (addr_q >= `A_SP_BASE) && (addr_q < `A_SP_END);
  assign sp_idx = 4'((addr_q - `A_SP_BASE) >> 2);

  always_comb begin
    rdata = 8'h00;
    if (sp_hit) begin
      rdata = sp_q[sp_idx];
    end else begin
      case (addr_q)
        `A_LOCAL_TEMP: rdata = local_temp_q;
        `A_REMOTE_HI: rdata = remote_temp_q[15:8];
        `A_REMOTE_LO: rdata = remote_temp_q[7:0];
        `A_CONFIG: rdata = cfg_q;
        `A_STATUS: rdata = {busy, 2'b00, status_q};
        `A_TACH_COUNT: rdata = tach_count_q[7:0];
        `A_IRQ_STATUS: rdata = {4'h0, irq_st_q};
        `A_IRQ_MASK: rdata = {4'h0, irq_mask_q};
        default: rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_en) begin
      hrdata <= (addr_q == `A_TACH_COUNT) ? {16'h0, tach_count_q} : {24'h0, rdata};
    end
  end

  // setpoint file, all eight-bit bytes; two's complement except rate and the low bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `SP_COUNT; i++) begin
        sp_q[i] <= 8'h00;
      end
      sp_q[`SP_LOCAL_HIGH] <= `RST_LOCAL_HIGH;
      sp_q[`SP_REMOTE_HIGH_HI] <= `RST_REMOTE_HIGH;
      sp_q[`SP_CRITICAL] <= `RST_CRITICAL;
      sp_q[`SP_HYSTERESIS] <= `RST_HYSTERESIS;
    end else if (wr_en && sp_hit) begin
      sp_q[sp_idx] <= hwdata[7:0];
    end
  end

  // status read in interrupt mode clears, and masks if a limit bit was set
  assign status_clr = rd_en && (addr_q == `A_STATUS) && !cfg_q[`CFG_CMP_MODE];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= `RST_CONFIG;
    end else if (wr_en && (addr_q == `A_CONFIG)) begin
      cfg_q <= hwdata[7:0];
    end else if (status_clr && |status_q[3:0]) begin
      cfg_q[`CFG_ALERT_MASK] <= 1'b1;
    end
  end

  // conversion sequencer; idle gap is (2^rate - 1) conversion times
  assign standby = cfg_q[`CFG_STANDBY];
  assign busy = (cv_q == CV_CONV);
  assign wait_len = (CONV_CYC << sp_q[`SP_RATE][2:0]) - CONV_CYC;
  assign conv_end = busy && !standby && (cv_cnt_q == CONV_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cv_q <= CV_IDLE;
      cv_cnt_q <= 32'h0;
    end else begin
      case (cv_q)
        CV_IDLE: begin
          cv_cnt_q <= 32'h0;
          if (!standby) begin
            cv_q <= CV_CONV;
          end
        end
        CV_CONV: begin
          if (standby) begin
            cv_q <= CV_IDLE;
          end else if (cv_cnt_q == CONV_CYC - 1) begin
            cv_cnt_q <= 32'h0;
            cv_q <= (wait_len == 32'h0) ? CV_CONV : CV_WAIT;
          end else begin
            cv_cnt_q <= cv_cnt_q + 32'h1;
          end
        end
        CV_WAIT: begin
          if (standby) begin
            cv_q <= CV_IDLE;
          // >= so that a rate cut in mid-wait cannot strand the count past the end
          end else if (cv_cnt_q + 32'h1 >= wait_len) begin
            cv_cnt_q <= 32'h0;
            cv_q <= CV_CONV;
          end else begin
            cv_cnt_q <= cv_cnt_q + 32'h1;
          end
        end
        default: begin
          cv_q <= CV_IDLE;
          cv_cnt_q <= 32'h0;
        end
      endcase
    end
  end

  AST_STANDBY_HALT: assert property (standby && !busy |=> !busy)
    else $error("conversion started in standby");

  // offset pair is an eleven-bit signed value left justified like the reading
  assign remote_sum = ({adc_remote, 5'h00} +
                       {sp_q[`SP_OFFSET_HI], sp_q[`SP_OFFSET_LO][7:5], 5'h00});

  // all compares run in a common signed 18-bit scale, integer degrees in bits 15:8
  assign t_loc = {{2{adc_local[7]}}, adc_local, 8'h00};
  assign t_rem = {{2{remote_sum[15]}}, remote_sum};
  assign hy = {{2{sp_q[`SP_HYSTERESIS][7]}}, sp_q[`SP_HYSTERESIS], 8'h00};

  // once tripped, a limit holds until the reading is past the limit by the hysteresis
  function automatic logic above(input wide_temp_t t, input wide_temp_t lim,
                                 input wide_temp_t h, input logic prev);
    above = prev ? (t > lim - h) : (t > lim);
  endfunction : above

  function automatic logic below(input wide_temp_t t, input wide_temp_t lim,
                                 input wide_temp_t h, input logic prev);
    below = prev ? (t < lim + h) : (t < lim);
  endfunction : below

  always_comb begin
    cond_d[`ST_LOCAL_HIGH] = above(t_loc,
      {{2{sp_q[`SP_LOCAL_HIGH][7]}}, sp_q[`SP_LOCAL_HIGH], 8'h00},
      hy, cond_q[`ST_LOCAL_HIGH]);
    cond_d[`ST_REMOTE_HIGH] = above(t_rem,
      {{2{sp_q[`SP_REMOTE_HIGH_HI][7]}}, sp_q[`SP_REMOTE_HIGH_HI], sp_q[`SP_REMOTE_HIGH_LO]},
      hy, cond_q[`ST_REMOTE_HIGH]);
    cond_d[`ST_REMOTE_LOW] = below(t_rem,
      {{2{sp_q[`SP_REMOTE_LOW_HI][7]}}, sp_q[`SP_REMOTE_LOW_HI], sp_q[`SP_REMOTE_LOW_LO]},
      hy, cond_q[`ST_REMOTE_LOW]);
    cond_d[`ST_CRITICAL] = above(t_rem,
      {{2{sp_q[`SP_CRITICAL][7]}}, sp_q[`SP_CRITICAL], 8'h00},
      hy, cond_q[`ST_CRITICAL]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_temp_q <= 8'h00;
      remote_temp_q <= 16'h0000;
      cond_q <= 4'h0;
    end else if (conv_end) begin
      local_temp_q <= adc_local;
      remote_temp_q <= {remote_sum[15:5], 5'h00};
      cond_q <= cond_d;
    end
  end

  AST_OFFSET_ADD: assert property (conv_end |=>
      remote_temp_q[15:5] == $past(remote_sum[15:5]))
    else $error("remote reading lost its offset");

  // comparator mode mirrors the conditions; interrupt mode is sticky and read-cleared
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 5'h00;
    end else if (cfg_q[`CFG_CMP_MODE]) begin
      if (conv_end) begin
        status_q <= {diode_open, cond_d};
      end
    end else begin
      // a conversion landing on the clearing read wins
      status_q <= (status_clr ? 5'h00 : status_q) |
                  (conv_end ? {diode_open, cond_d} : 5'h00);
    end
  end

  AST_LOCAL_FLAG: assert property (conv_end && !cfg_q[`CFG_CMP_MODE] &&
      cond_d[`ST_LOCAL_HIGH] |=> status_q[`ST_LOCAL_HIGH])
    else $error("local high violation not flagged");

  AST_REMOTE_LOW_FLAG: assert property (conv_end && cond_d[`ST_REMOTE_LOW]
      |=> status_q[`ST_REMOTE_LOW])
    else $error("remote low violation not flagged");

  sequence s_status_read;
    status_clr && |status_q[3:0] && !conv_end;
  endsequence

  sequence s_cleared_masked;
    status_q == 5'h00 && cfg_q[`CFG_ALERT_MASK];
  endsequence

  AST_READ_CLEARS: assert property (s_status_read |=> s_cleared_masked)
    else $error("status read did not clear and mask");

  // shared pin: alert open-drain or tach input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_tach_oe <= 1'b0;
    end else begin
      alert_tach_oe <= !cfg_q[`CFG_TACH_SEL] && !cfg_q[`CFG_ALERT_MASK] &&
                       |status_q[3:0];
    end
  end
  assign alert_tach_o = 1'b0;

  AST_ALERT_DRIVE: assert property (!cfg_q[`CFG_TACH_SEL] &&
      !cfg_q[`CFG_ALERT_MASK] && |status_q[3:0] |=> alert_tach_oe)
    else $error("violation did not pull alert low");

  AST_ALERT_MASKED: assert property (cfg_q[`CFG_ALERT_MASK] |=> !alert_tach_oe)
    else $error("alert driven while masked");

  AST_TACH_NO_DRIVE: assert property (cfg_q[`CFG_TACH_SEL] |=> !alert_tach_oe)
    else $error("alert driven in tach mode");

  // tach period counted in ticks of the slow counter clock, saturating at full scale
  assign tach_edge = cfg_q[`CFG_TACH_SEL] && (cfg_q[`CFG_SMART_TACH] ?
    (tach_f && hi_run_q == 2'(`TACH_SMART_MIN - 1)) : (tach_f && !tach_prev_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tach_prev_q <= 1'b0;
      hi_run_q <= 2'h0;
      div_q <= 7'h00;
    end else begin
      tach_prev_q <= tach_f;
      div_q <= (div_q == 7'(`TACH_DIV - 1)) ? 7'h00 : div_q + 7'h01;
      // short highs from pwm-chopped fan power never reach the run length
      if (!tach_f) begin
        hi_run_q <= 2'h0;
      end else if (hi_run_q != 2'(`TACH_SMART_MIN)) begin
        hi_run_q <= hi_run_q + 2'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_q <= 16'h0000;
      tach_count_q <= `TACH_FULL;
    end else if (tach_edge) begin
      tach_count_q <= per_q;
      per_q <= 16'h0000;
    end else if (div_q == 7'h00 && per_q != `TACH_FULL) begin
      per_q <= per_q + 16'h0001;
    end
  end

  AST_TACH_CAPTURE: assert property (tach_edge |=>
      tach_count_q == $past(per_q) && per_q == 0)
    else $error("tach period not captured");

  // fan pwm and serial line drivers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_pwm_oe <= 1'b0;
      smb_scl_oe <= 1'b0;
      smb_sda_oe <= 1'b0;
    end else begin
      fan_pwm_oe <= fan_pwm_req && !(standby && cfg_q[`CFG_PWM_SB_DIS]);
      smb_scl_oe <= smb_scl_drive && !to_hold;
      smb_sda_oe <= smb_sda_drive && !to_hold;
    end
  end
  assign fan_pwm_o = 1'b0;
  assign smb_scl_o = 1'b0;
  assign smb_sda_o = 1'b0;
  assign smb_if_reset = to_pulse;

  AST_PWM_STANDBY: assert property (standby && cfg_q[`CFG_PWM_SB_DIS] |=>
      !fan_pwm_oe)
    else $error("fan pwm driven in standby");

  AST_SMB_RELEASE: assert property (to_hold |=> !smb_scl_oe && !smb_sda_oe)
    else $error("serial lines driven after timeout");

  // interrupt status: write one to clear, a new event in the same cycle wins
  assign irq_ev = {to_pulse, tach_edge, conv_end && |cond_d, conv_end};
  assign w1c = (wr_en && addr_q == `A_IRQ_STATUS) ? hwdata[3:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= 4'h0;
      irq_mask_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~w1c) | irq_ev;
      if (wr_en && addr_q == `A_IRQ_MASK) begin
        irq_mask_q <= hwdata[3:0];
      end
      irq <= |(irq_st_q & irq_mask_q);
    end
  end
endmodule : temp_monitor_limit_alert_core

/* dv/smb_host_model.sv */
// serial bus host model: clocks frames, can hold the clock low, resolves the open-drain lines
`timescale 1ns/10ps
module smb_host_model (
  input wire logic frame,
  input wire logic hold_low,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic scl_pull = 1'b0;
  // clock stands released between frames, as a real host leaves it
  always begin
    #400;
    scl_pull = frame ? ~scl_pull : 1'b0;
  end
  // pull-ups: high unless a party pulls low; hold_low stalls the bus
  assign scl = !(scl_pull | hold_low | scl_oe);
  assign sda = !sda_oe;
endmodule : smb_host_model

/* dv/temp_monitor_limit_alert_core_tb.sv */
// self-checking testbench of the temperature monitor core
`timescale 1ns/10ps
module temp_monitor_limit_alert_core_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] adc_local = 8'h0;
  logic [10:0] adc_remote = 11'h0;
  logic diode_open = 1'b0;
  logic fan_pwm_req = 1'b0;
  logic smb_scl_drive = 1'b0;
  logic smb_sda_drive = 1'b0;
  logic alert_tach_i = 1'b0;
  logic frame = 1'b0;
  logic hold_low = 1'b0;
  logic hreadyout, irq, smb_if_reset, fan_pwm_oe, alert_tach_oe, smb_scl_oe, smb_sda_oe;
  logic smb_scl_i, smb_sda_i;
  logic hresp, fan_pwm_o, alert_tach_o, smb_scl_o, smb_sda_o;
  logic [31:0] hrdata;
  wire hready = hreadyout;
  int err_count = 0;
  int comparisons = 0;
  int n;
  time t0, t1;
  logic [7:0] ra [8] = '{8'h0c, 8'h14, 8'h18, 8'h1c, 8'h28, 8'h2c, 8'h3c, 8'h44};
  logic [31:0] rv [8] = '{32'h0, 32'h46, 32'h46, 32'h0, 32'h55, 32'h4, 32'hffff, 32'h0};

  always #50 hclk = ~hclk;

  temp_monitor_limit_alert_core #(.CONV_CYC(50), .SMB_TO_CYC(100)) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .adc_local, .adc_remote, .diode_open, .fan_pwm_req,
    .fan_pwm_o, .fan_pwm_oe, .smb_scl_i, .smb_scl_drive, .smb_scl_o, .smb_scl_oe,
    .smb_sda_i, .smb_sda_drive, .smb_sda_o, .smb_sda_oe, .smb_if_reset, .alert_tach_i,
    .alert_tach_o, .alert_tach_oe, .irq
  );

  smb_host_model host (.frame, .hold_low, .scl_oe(smb_scl_oe), .sda_oe(smb_sda_oe),
    .scl(smb_scl_i), .sda(smb_sda_i));

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic tmo();
    err_count++;
    $display("[ERR] t=%0t wait ran out", $time);
    conclude();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // hreadyout is combinational, so it is looked at mid-cycle and taken at the next edge
  task automatic ready();
    logic r;
    for (int i = 0; i < 20; i++) begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
      if (r === 1'b1) return;
    end
    tmo();
  endtask : ready

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready();
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(negedge hclk);
  endtask : idle

  // clears the event flags and waits for two conversion-done interrupts
  task automatic conv();
    repeat (2) begin
      wr(8'h40, 32'hf);
      n = 0;
      do begin
        @(negedge hclk);
        n++;
      end while (irq !== 1'b1 && n < 900);
      if (irq !== 1'b1) tmo();
      t0 = t1;
      t1 = $time;
    end
  endtask : conv

  task automatic meas(input logic [7:0] l, input logic [10:0] r);
    @(posedge hclk);
    adc_local <= l;
    adc_remote <= r;
    conv();
  endtask : meas

  // three tach edges 1110 clocks apart; g adds a two-clock glitch that passes the pin filter
  task automatic tach(input logic g);
    repeat (3) begin
      @(posedge hclk) alert_tach_i <= 1'b1;
      repeat (20) @(posedge hclk);
      alert_tach_i <= 1'b0;
      repeat (500) @(posedge hclk);
      alert_tach_i <= g;
      repeat (2) @(posedge hclk);
      alert_tach_i <= 1'b0;
      repeat (587) @(posedge hclk);
    end
  endtask : tach

  initial begin
    logic [31:0] q;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i], 32'hffff);
    wr(8'h14, 32'h1ff);
    rd(8'h14, 32'hff, 32'hffff);
    wr(8'h14, 32'h46);
    wr(8'h48, 32'h5a);
    rd(8'h48, 32'h0, 32'hffff);
    wr(8'h44, 32'h1);
    wr(8'h38, 32'h1);
    conv();
    chk(32'((t1 - t0) / 100), 100);
    wr(8'h38, 32'h0);
    conv();
    chk(32'((t1 - t0) / 100), 50);
    $display("test registers done");
    wr(8'h0c, 32'h1);
    meas(8'h47, 11'h0);
    rd(8'h00, 32'h47, 32'hff);
    rd(8'h10, 32'h01, 32'h7f);
    idle(2);
    chk(alert_tach_oe, 1);
    meas(8'h44, 11'h0);
    rd(8'h10, 32'h01, 32'h7f);
    @(posedge hclk) diode_open <= 1'b1;
    meas(8'h42, 11'h0);
    rd(8'h10, 32'h10, 32'h7f);
    idle(2);
    chk(alert_tach_oe, 0);
    @(posedge hclk) diode_open <= 1'b0;
    $display("test local limit done");
    wr(8'h30, 32'h2);
    wr(8'h34, 32'h3f);
    meas(8'h0, 11'h0c8);
    rd(8'h04, 32'h1b, 32'hff);
    rd(8'h08, 32'h20, 32'hff);
    wr(8'h30, 32'hff);
    wr(8'h34, 32'h0);
    meas(8'h0, 11'h7f0);
    rd(8'h04, 32'hfd, 32'hff);
    rd(8'h10, 32'h04, 32'h7f);
    wr(8'h30, 32'h0);
    wr(8'h28, 32'h47);
    meas(8'h0, 11'h240);
    rd(8'h10, 32'h0a, 32'h7f);
    wr(8'h0c, 32'h81);
    idle(2);
    chk(alert_tach_oe, 0);
    wr(8'h0c, 32'h5);
    idle(2);
    chk(alert_tach_oe, 0);
    $display("test remote limits done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h0c, k ? 32'h6 : 32'h4);
      tach(k[0]);
      xfer(1'b0, 8'h3c, 32'h0, q);
      chk(q >= 9 && q <= 11, 1);
    end
    $display("test tach done");
    wr(8'h0c, 32'h0);
    conv();
    wr(8'h0c, 32'h40);
    rd(8'h10, 32'h0a, 32'hff);
    rd(8'h0c, 32'hc0, 32'hff);
    rd(8'h10, 32'h0, 32'hff);
    @(posedge hclk) fan_pwm_req <= 1'b1;
    wr(8'h0c, 32'h60);
    idle(2);
    chk(fan_pwm_oe, 0);
    wr(8'h0c, 32'h40);
    idle(2);
    chk(fan_pwm_oe, 1);
    wr(8'h40, 32'hf);
    idle(150);
    rd(8'h40, 32'h0, 32'hf);
    wr(8'h44, 32'h0);
    wr(8'h0c, 32'h0);
    idle(150);
    chk(irq, 0);
    rd(8'h40, 32'h3, 32'hf);
    rd(8'h10, 32'h0a, 32'h7f);
    wr(8'h44, 32'h1);
    idle(2);
    chk(irq, 1);
    $display("test standby and interrupt done");
    @(posedge hclk) frame <= 1'b1;
    smb_sda_drive <= 1'b1;
    idle(40);
    chk(smb_sda_oe, 1);
    @(posedge hclk) smb_sda_drive <= 1'b0;
    frame <= 1'b0;
    wr(8'h40, 32'hf);
    rd(8'h40, 32'h0, 32'h8);
    @(posedge hclk) hold_low <= 1'b1;
    smb_sda_drive <= 1'b1;
    smb_scl_drive <= 1'b1;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (smb_if_reset !== 1'b1 && n < 200);
    chk(n >= 100 && n <= 106, 1);
    idle(4);
    chk(smb_scl_oe | smb_sda_oe, 0);
    @(posedge hclk) hold_low <= 1'b0;
    idle(20);
    chk(smb_scl_oe & smb_sda_oe, 1);
    @(posedge hclk) smb_sda_drive <= 1'b0;
    smb_scl_drive <= 1'b0;
    rd(8'h40, 32'h8, 32'h8);
    chk({27'h0, hresp, fan_pwm_o, alert_tach_o, smb_scl_o, smb_sda_o}, 32'h0);
    $display("test bus timeout done");
    conclude();
  end
endmodule : temp_monitor_limit_alert_core_tb
